// ---- counter_preset_limit_command_decoder.sv ----
// Preset, limit, sense and time-base command decoder of the counter
//
// Contract
// - Codes 16-19 load output presets 1-4 from command data.
// - Codes 20-27 load internal presets 1-8 from command data.
// - Preset outside lower..upper limit: error returned, preset kept.
// - Presets, accumulator and lower limit reset to zero.
// - Code 32 loads accumulator; out-of-limit value rejected with error.
// - Code 33 loads upper limit; span under 128 rejected; resets 8388607.
// - Code 34 loads lower limit with same span check.
// - Code 35 loads the comparison sense bits from command data.
// - Code 36 loads time base; outside 1..65535 rejected.
// - Codes 48-51 return output presets 1-4.
// - Codes 52-59 return internal presets 1-8.
// - Code 64 returns the accumulator.
// - Codes 65-68 return upper, lower, sense and time base.
// - Readback answers carry data type 011.
// - Rejected command answers type 100 with code, state unchanged.
// - Last requested type repeats every scan; accumulator after reset.
// - While the power-up flag is set every command is ignored.
`timescale 1ns/1ps
`include "counter_params.svh"

module counter_preset_limit_command_decoder
  import counter_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire cmd_t cmd,
  input wire logic powerup_flag,
  output reply_t reply,
  output cfg_t cfg
);
  state_t st_q;
  state_t st_d;
  logic within_limits;
  logic upper_span_ok;
  logic lower_span_ok;

  // Sorts a command byte into the job it asks for
  function automatic cmd_class_t cmd_class(input logic [7:0] code);
    if (code >= `CMD_LOAD_PRE_FIRST && code <= `CMD_LOAD_PRE_LAST) begin
      return CL_LOAD_PRE;
    end
    if (code >= `CMD_READ_PRE_FIRST && code <= `CMD_READ_PRE_LAST) begin
      return CL_READ_OTHER;
    end
    if (code >= `CMD_READ_UPPER && code <= `CMD_READ_TB) begin
      return CL_READ_OTHER;
    end
    case (code)
      `CMD_LOAD_ACC: return CL_LOAD_ACC;
      `CMD_LOAD_UPPER: return CL_LOAD_UPPER;
      `CMD_LOAD_LOWER: return CL_LOAD_LOWER;
      `CMD_LOAD_SENSE: return CL_LOAD_SENSE;
      `CMD_LOAD_TB: return CL_LOAD_TB;
      `CMD_READ_ACC: return CL_READ_ACC;
      default: return CL_NONE;
    endcase
  endfunction

  // Value returned for a readback code
  function automatic logic [23:0] readback(input logic [7:0] code,
                                           input cfg_t c);
    logic [3:0] idx;
    idx = 4'(code - `CMD_READ_PRE_FIRST);
    if (code >= `CMD_READ_PRE_FIRST && code <= `CMD_READ_PRE_LAST) begin
      return c.preset[idx];
    end
    case (code)
      `CMD_READ_UPPER: return c.upper;
      `CMD_READ_LOWER: return c.lower;
      `CMD_READ_SENSE: return c.sense;
      `CMD_READ_TB: return {8'h00, c.timebase};
      default: return c.accum;
    endcase
  endfunction

  // Data treated as signed against the current limits
  cmd_range_check u_check (
    .value(cmd.data),
    .upper(st_q.cfg.upper),
    .lower(st_q.cfg.lower),
    .within_limits(within_limits),
    .upper_span_ok(upper_span_ok),
    .lower_span_ok(lower_span_ok)
  );

  // Decode one scan's command and build the answer
  always_comb begin
    logic err;
    logic [23:0] err_code;
    logic [3:0] idx;
    err = 1'b0;
    err_code = 24'h000000;
    idx = 4'(cmd.command_byte_code - `CMD_LOAD_PRE_FIRST);
    st_d = st_q;
    st_d.reply.valid = 1'b0;
    if (cmd.valid) begin
      st_d.reply.valid = 1'b1;
      // Power-up blocks all work here; card reset is handled elsewhere
      if (!powerup_flag) begin
        unique case (cmd_class(cmd.command_byte_code))
          CL_LOAD_PRE: begin
            if (within_limits) begin
              st_d.cfg.preset[idx] = cmd.data;
            end else begin
              err = 1'b1;
              err_code = `ERR_PRESET_RANGE;
            end
          end
          CL_LOAD_ACC: begin
            if (within_limits) begin
              st_d.cfg.accum = cmd.data;
            end else begin
              err = 1'b1;
              err_code = `ERR_ACCUM_RANGE;
            end
          end
          CL_LOAD_UPPER: begin
            if (upper_span_ok) begin
              st_d.cfg.upper = cmd.data;
            end else begin
              err = 1'b1;
              err_code = `ERR_LIMIT_SPAN;
            end
          end
          CL_LOAD_LOWER: begin
            if (lower_span_ok) begin
              st_d.cfg.lower = cmd.data;
            end else begin
              err = 1'b1;
              err_code = `ERR_LIMIT_SPAN;
            end
          end
          CL_LOAD_SENSE: begin
            st_d.cfg.sense = cmd.data;
          end
          CL_LOAD_TB: begin
            if (cmd.data[23:16] == 8'h00 && cmd.data[15:0] != 16'h0000) begin
              st_d.cfg.timebase = cmd.data[15:0];
            end else begin
              err = 1'b1;
              err_code = `ERR_TIMEBASE;
            end
          end
          CL_READ_ACC: begin
            st_d.sel = RET_ACCUM;
          end
          CL_READ_OTHER: begin
            st_d.sel = RET_READBACK;
            st_d.rb_code = cmd.command_byte_code;
          end
          CL_NONE: begin
            // Unassigned or out-of-scope codes change nothing
            st_d.sel = st_q.sel;
          end
        endcase
      end
      // Error shows for one scan; the standing selection then resumes
      if (err) begin
        st_d.reply.dtype = `DTYPE_ERROR;
        st_d.reply.data = err_code;
      end else if (st_d.sel == RET_ACCUM) begin
        st_d.reply.dtype = `DTYPE_ACCUM;
        st_d.reply.data = st_d.cfg.accum;
      end else begin
        st_d.reply.dtype = `DTYPE_READBACK;
        st_d.reply.data = readback(st_d.rb_code, st_d.cfg);
      end
    end
  end

  // State register; defaults while rstn is low
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_q.cfg.preset <= {12{`PRESET_RST}};
      st_q.cfg.accum <= `ACCUM_RST;
      st_q.cfg.upper <= `UPPER_RST;
      st_q.cfg.lower <= `LOWER_RST;
      st_q.cfg.sense <= `SENSE_RST;
      st_q.cfg.timebase <= `TIMEBASE_RST;
      st_q.sel <= RET_ACCUM;
      st_q.rb_code <= 8'h00;
      st_q.reply <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign reply = st_q.reply;
  assign cfg = st_q.cfg;

  // Checks on the decoder
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic live;
  cmd_class_t cls;
  assign live = cmd.valid && !powerup_flag;
  assign cls = cmd_class(cmd.command_byte_code);

  sequence s_read_req;
    live && cls == CL_READ_OTHER;
  endsequence

  sequence s_quiet_scan;
    cmd.valid && (powerup_flag || cls == CL_NONE);
  endsequence

  a_preset_load: assert property (
    live && cls == CL_LOAD_PRE && within_limits |=>
      cfg.preset[4'($past(cmd.command_byte_code) - `CMD_LOAD_PRE_FIRST)]
        == $past(cmd.data))
    else $error("preset not loaded");

  a_preset_reject: assert property (
    live && cls == CL_LOAD_PRE && !within_limits |=>
      $stable(cfg.preset) && reply.dtype == `DTYPE_ERROR &&
      reply.data == `ERR_PRESET_RANGE)
    else $error("bad preset not rejected");

  a_accum_reject: assert property (
    live && cls == CL_LOAD_ACC && !within_limits |=>
      $stable(cfg.accum) && reply.dtype == `DTYPE_ERROR)
    else $error("bad accumulator load accepted");

  a_limit_span: assert property (
    ($signed({cfg.upper[23], cfg.upper}) -
     $signed({cfg.lower[23], cfg.lower})) >= `MIN_SPAN)
    else $error("limit span under minimum");

  a_lower_load: assert property (
    live && cls == CL_LOAD_LOWER && lower_span_ok |=>
      cfg.lower == $past(cmd.data) && reply.dtype != `DTYPE_ERROR)
    else $error("lower limit not loaded");

  a_timebase_range: assert property (
    cfg.timebase != 16'h0000)
    else $error("time base left range");

  a_readback_type: assert property (
    s_read_req ##1 !cmd.valid ##1 s_quiet_scan |=>
      reply.valid && reply.dtype == `DTYPE_READBACK)
    else $error("readback type not kept");

  a_powerup_ignore: assert property (
    s_quiet_scan |=> $stable(cfg) && reply.valid &&
      reply.dtype != `DTYPE_ERROR)
    else $error("command acted during power-up");

  a_reply_pulse: assert property (
    cmd.valid |=> reply.valid ##1 (reply.valid == $past(cmd.valid)))
    else $error("answer not one per scan");
endmodule

// ---- counter_params.svh ----
// Constants for the preset, limit and time-base command decoder
`ifndef COUNTER_PARAMS_SVH
`define COUNTER_PARAMS_SVH

// Command codes
`define CMD_LOAD_PRE_FIRST 8'h10
`define CMD_LOAD_PRE_LAST 8'h1B
`define CMD_LOAD_ACC 8'h20
`define CMD_LOAD_UPPER 8'h21
`define CMD_LOAD_LOWER 8'h22
`define CMD_LOAD_SENSE 8'h23
`define CMD_LOAD_TB 8'h24
`define CMD_READ_PRE_FIRST 8'h30
`define CMD_READ_PRE_LAST 8'h3B
`define CMD_READ_ACC 8'h40
`define CMD_READ_UPPER 8'h41
`define CMD_READ_LOWER 8'h42
`define CMD_READ_SENSE 8'h43
`define CMD_READ_TB 8'h44

// Returned data type field codes
`define DTYPE_ACCUM 3'h0
`define DTYPE_READBACK 3'h3
`define DTYPE_ERROR 3'h4

// Error codes placed in the returned data bytes
`define ERR_PRESET_RANGE 24'h000001
`define ERR_ACCUM_RANGE 24'h000002
`define ERR_LIMIT_SPAN 24'h000003
`define ERR_TIMEBASE 24'h000004

// Reset values
`define PRESET_RST 24'h000000
`define ACCUM_RST 24'h000000
`define UPPER_RST 24'h7FFFFF
`define LOWER_RST 24'h000000
`define SENSE_RST 24'h000000
`define TIMEBASE_RST 16'h03E8

// Least span between upper and lower count limit
`define MIN_SPAN 25'sh0000080

`endif

// ---- counter_pkg.sv ----
// Types shared by the command decoder files
package counter_pkg;

  // One scan's command from the host
  typedef struct packed {
    logic valid;
    logic [7:0] command_byte_code;
    logic [23:0] data;
  } cmd_t;

  // One scan's answer to the host
  typedef struct packed {
    logic valid;
    logic [2:0] dtype;
    logic [23:0] data;
  } reply_t;

  // Values held for the counting datapath
  typedef struct packed {
    logic [11:0][23:0] preset;
    logic [23:0] accum;
    logic [23:0] upper;
    logic [23:0] lower;
    logic [23:0] sense;
    logic [15:0] timebase;
  } cfg_t;

  typedef enum logic {RET_ACCUM, RET_READBACK} ret_kind_t;

  typedef enum logic [3:0] {
    CL_NONE, CL_LOAD_PRE, CL_LOAD_ACC, CL_LOAD_UPPER, CL_LOAD_LOWER,
    CL_LOAD_SENSE, CL_LOAD_TB, CL_READ_ACC, CL_READ_OTHER
  } cmd_class_t;

  typedef struct packed {
    cfg_t cfg;
    ret_kind_t sel;
    logic [7:0] rb_code;
    reply_t reply;
  } state_t;

endpackage

// ---- cmd_range_check.sv ----
// Signed limit and span checks for a proposed 24-bit value
`timescale 1ns/1ps
`include "counter_params.svh"

module cmd_range_check (
  input wire logic [23:0] value,
  input wire logic [23:0] upper,
  input wire logic [23:0] lower,
  output logic within_limits,
  output logic upper_span_ok,
  output logic lower_span_ok
);
  logic signed [24:0] v;
  logic signed [24:0] u;
  logic signed [24:0] l;

  // Sign-extend by one bit so differences cannot overflow
  assign v = {value[23], value};
  assign u = {upper[23], upper};
  assign l = {lower[23], lower};

  // Value as load for the accumulator or a preset
  assign within_limits = (v <= u) && (v >= l);
  // Value as a new upper limit, then as a new lower limit
  assign upper_span_ok = (v - l) >= `MIN_SPAN;
  assign lower_span_ok = (u - v) >= `MIN_SPAN;
endmodule

// ---- host_model.sv ----
// Host-side model that hands one command per scan to the decoder
`timescale 1ns/1ps
module host_model
  import counter_pkg::*;
(
  input wire logic clk,
  input wire cmd_t req,
  output cmd_t cmd
);
  logic [23:0] last_q = 24'h5A5A5A;

  // Idle scans carry a changing pattern, never stale data
  always_ff @(posedge clk) begin
    last_q <= cmd.data;
  end

  // Unassigned codes from 0x1C up are never sent to the module; codes 0x00-0x0F pass through
  always_comb begin
    cmd = req;
    if (!req.valid) begin
      cmd.data = ~last_q;
    end
    if (req.command_byte_code inside {[8'h1C:8'h1F], [8'h25:8'h2F],
        [8'h3C:8'h3F]} || req.command_byte_code > 8'h44) begin
      cmd.valid = 1'b0;
    end
  end
endmodule

// ---- testbench.sv ----
// Scan-level testbench for the preset and limit command decoder
`timescale 1ns/1ps
`include "counter_params.svh"
module testbench
  import counter_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic powerup_flag = 1'b0;
  cmd_t req = '0;
  cmd_t cmd;
  reply_t reply;
  cfg_t cfg;
  int bad_count = 0;
  int check_count = 0;

  // 125 MHz clock
  initial begin
    forever #4 clk = ~clk;
  end

  host_model host_u (.clk(clk), .req(req), .cmd(cmd));
  counter_preset_limit_command_decoder dut_u (.clk(clk), .rstn(rstn),
    .cmd(cmd), .powerup_flag(powerup_flag), .reply(reply), .cfg(cfg));

  // Compare of a stored value
  task automatic chk(input string what, input logic [23:0] exp,
      input logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Compare of the answer pulse, type and data
  task automatic chk_reply(input logic [2:0] t, input logic [23:0] d);
    check_count++;
    if (reply.valid !== 1'b1 || reply.dtype !== t || reply.data !== d) begin
      bad_count++;
      $display("Error reply expected %h %h seen %b %h %h", t, d,
        reply.valid, reply.dtype, reply.data);
    end
  endtask

  // One scan; an idle cycle first so valid is never rewritten in a step
  task automatic scan(input logic [7:0] code, input logic [23:0] d);
    @(posedge clk);
    #1;
    req.valid = 1'b1;
    req.command_byte_code = code;
    req.data = d;
    @(posedge clk);
    #1;
    req.valid = 1'b0;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (2000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    #1;
    rstn = 1'b1;
    // Null code right after reset shows the default accumulator answer
    scan(8'h02, 24'h123456);
    chk_reply(`DTYPE_ACCUM, 24'h000000);
    scan(8'h40, 24'h000000);
    chk_reply(`DTYPE_ACCUM, 24'h000000);
    scan(8'h41, 24'h000000);
    chk_reply(`DTYPE_READBACK, 24'h7FFFFF);
    scan(8'h42, 24'h000000);
    chk_reply(`DTYPE_READBACK, 24'h000000);
    // Every preset loaded and read back with its own value
    for (int i = 0; i < 12; i++) begin
      scan(8'h10 + i[7:0], 24'h000005 + i[23:0]);
      chk("preset", 24'h000005 + i[23:0], cfg.preset[i]);
      scan(8'h30 + i[7:0], 24'h000000);
      chk_reply(`DTYPE_READBACK, 24'h000005 + i[23:0]);
    end
    scan(8'h22, 24'hFFFF38);
    chk("lower", 24'hFFFF38, cfg.lower);
    scan(8'h10, 24'h800000);
    chk_reply(`DTYPE_ERROR, `ERR_PRESET_RANGE);
    chk("preset", 24'h000005, cfg.preset[0]);
    // Span of 127 refused, 128 taken
    scan(8'h21, 24'hFFFFB7);
    chk_reply(`DTYPE_ERROR, `ERR_LIMIT_SPAN);
    chk("upper", 24'h7FFFFF, cfg.upper);
    scan(8'h21, 24'hFFFFB8);
    chk("upper", 24'hFFFFB8, cfg.upper);
    scan(8'h22, 24'hFFFF39);
    chk_reply(`DTYPE_ERROR, `ERR_LIMIT_SPAN);
    chk("lower", 24'hFFFF38, cfg.lower);
    // Accumulator just above and exactly at the upper limit
    scan(8'h20, 24'hFFFFB9);
    chk_reply(`DTYPE_ERROR, `ERR_ACCUM_RANGE);
    scan(8'h20, 24'hFFFFB8);
    chk("accum", 24'hFFFFB8, cfg.accum);
    scan(8'h40, 24'h000000);
    chk_reply(`DTYPE_ACCUM, 24'hFFFFB8);
    scan(8'h22, 24'h800000);
    chk("lower", 24'h800000, cfg.lower);
    scan(8'h23, 24'hABCDEF);
    scan(8'h43, 24'h000000);
    chk_reply(`DTYPE_READBACK, 24'hABCDEF);
    // Time base outside 1..65535 refused
    scan(8'h24, 24'h000000);
    chk_reply(`DTYPE_ERROR, `ERR_TIMEBASE);
    scan(8'h24, 24'h010000);
    chk("timebase", 24'h0003E8, {8'h00, cfg.timebase});
    scan(8'h24, 24'h00FFFF);
    scan(8'h44, 24'h000000);
    chk_reply(`DTYPE_READBACK, 24'h00FFFF);
    // Code with no job here keeps the standing readback and the time base
    scan(8'h02, 24'h7FFFFF);
    chk_reply(`DTYPE_READBACK, 24'h00FFFF);
    chk("timebase", 24'h00FFFF, {8'h00, cfg.timebase});
    // Error lasts one answer, then the selection resumes
    scan(8'h24, 24'h000000);
    chk_reply(`DTYPE_ERROR, `ERR_TIMEBASE);
    scan(8'h23, 24'h123456);
    chk_reply(`DTYPE_READBACK, 24'h00FFFF);
    chk("sense", 24'h123456, cfg.sense);
    // Commands ignored while the power-up flag is up
    powerup_flag = 1'b1;
    scan(8'h23, 24'h000000);
    chk("sense", 24'h123456, cfg.sense);
    chk_reply(`DTYPE_READBACK, 24'h00FFFF);
    powerup_flag = 1'b0;
    tally_and_finish();
  end
endmodule
